//--- rtl/fire_alarm_pkg.sv
// constants, register map and config type for the fire alarm decision block
package fire_alarm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SECOND_NS     = 1_000_000_000;
  localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

  localparam int unsigned A_REPEAT_S     = 60;
  localparam int unsigned A_PERIOD_MAX_M = 30;
  localparam int unsigned A_PERIOD_MAX_S = A_PERIOD_MAX_M * 60;
  localparam int unsigned B_PERIOD_MIN_M = 5;
  localparam int unsigned B_PERIOD_MIN_S = B_PERIOD_MIN_M * 60;

  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_CFG         = 8'h04;
  localparam logic [7:0] REG_ACCESS      = 8'h08;
  localparam logic [7:0] REG_A_PERIOD    = 8'h0C;
  localparam logic [7:0] REG_B_PERIOD    = 8'h10;
  localparam logic [7:0] REG_DLY_INIT    = 8'h14;
  localparam logic [7:0] REG_DLY_EXT     = 8'h18;
  localparam logic [7:0] REG_DLY_MAX     = 8'h1C;
  localparam logic [7:0] REG_DAY_LEN     = 8'h20;
  localparam logic [7:0] REG_FAULT_LATCH = 8'h24;
  localparam logic [7:0] REG_STATUS      = 8'h28;
  localparam logic [7:0] REG_ZONE_ALARM  = 8'h2C;
  localparam logic [7:0] REG_POINT_ALARM = 8'h30;
  localparam logic [7:0] REG_FAULT_STAT  = 8'h34;

  localparam int unsigned CMD_CANCEL_B  = 0;
  localparam int unsigned CMD_EXTEND    = 1;
  localparam int unsigned CMD_DAY_ON    = 2;
  localparam int unsigned CMD_DAY_OFF   = 3;
  localparam int unsigned CMD_FAULT_RST = 4;
  localparam int unsigned CMD_ALARM_RST = 5;
  localparam int unsigned CMD_NEWZ_CLR  = 6;
  localparam int unsigned CMD_WIDTH     = 7;

  localparam logic [2:0] LVL_RST      = 3'h1;
  localparam logic [2:0] LVL_OPERATOR = 3'h2;
  localparam logic [2:0] LVL_CONFIG   = 3'h3;
  localparam logic [2:0] LVL_TOP      = 3'h4;

  localparam logic [10:0] A_PERIOD_RST = 11'h03C;
  localparam logic [15:0] B_PERIOD_RST = 16'h012C;
  localparam logic [9:0]  DLY_INIT_RST = 10'h01E;
  localparam logic [9:0]  DLY_EXT_RST  = 10'h03C;
  localparam logic [9:0]  DLY_MAX_RST  = 10'h258;
  localparam logic [19:0] DAY_LEN_RST  = 20'hA8C0;

  typedef struct packed {
    logic mcp_delay;
    logic mcp_override;
    logic delays_perm;
    logic b_auto;
    logic dep_c;
    logic dep_b;
    logic dep_a;
  } cfg_t;

  localparam cfg_t CFG_RST = 7'h00;

endpackage

//--- rtl/fire_alarm_dependency_ctrl.sv
// alarm decision, dependency, output delay and fault indication logic with apb registers
`timescale 1ns/1ps
`default_nettype none
module fire_alarm_dependency_ctrl #(
  parameter int unsigned NUM_ZONES    = 4,
  parameter int unsigned PTS_PER_ZONE = 4,
  parameter int unsigned NUM_FAULTS   = 8,
  parameter int unsigned TICK_CYCLES  = fire_alarm_pkg::SEC_CYCLES
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [7:0]              paddr_in,
  input  wire logic [31:0]             pwdata_in,
  output logic      [31:0]             prdata_out,
  output logic                         pready_out,
  output logic                         pslverr_out,
  input  wire logic [NUM_ZONES*PTS_PER_ZONE-1:0] det_fire_in,
  input  wire logic [NUM_ZONES-1:0]    mcp_fire_in,
  input  wire logic [NUM_FAULTS-1:0]   fault_in,
  input  wire logic                    sys_fault_in,
  output logic                         alarm_out,
  output logic                         outputs_active_out,
  output logic                         first_alarm_out,
  output logic                         local_warn_out,
  output logic      [NUM_ZONES-1:0]    zone_reset_out,
  output logic      [NUM_ZONES-1:0]    zone_alarm_out,
  output logic                         new_zone_out,
  output logic                         delays_on_out,
  output logic                         fault_out,
  output logic                         sys_fault_out
);
  localparam int unsigned NP = NUM_ZONES * PTS_PER_ZONE;

  if (NP > 32 || NP < 2 || NUM_FAULTS > 32 || NUM_FAULTS < 1 || TICK_CYCLES < 2) begin : g_bad_params
    $error("fire_alarm_dependency_ctrl: unsupported parameter values");
  end

  function automatic logic [NUM_ZONES-1:0] zones_of(input logic [NP-1:0] pts);
    logic [NUM_ZONES-1:0] z;
    z = '0;
    for (int i = 0; i < NP; i++) begin
      if (pts[i]) begin
        z[i / PTS_PER_ZONE] = 1'b1;
      end
    end
    return z;
  endfunction

  function automatic logic [5:0] pop(input logic [31:0] v);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < 32; i++) begin
      n = n + 6'(v[i]);
    end
    return n;
  endfunction

  function automatic logic [19:0] clamp(input logic [19:0] v, input logic [19:0] lo, input logic [19:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // synchronisers; the meta stage feeds only the sync stage
  logic [NP-1:0]         det_meta, det_sync, det_prev;
  logic [NUM_ZONES-1:0]  mcp_meta, mcp_sync, mcp_prev;
  logic [NUM_FAULTS-1:0] fault_meta, fault_sync;
  logic                  sys_meta, sys_sync;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_meta   <= '0;
      det_sync   <= '0;
      det_prev   <= '0;
      mcp_meta   <= '0;
      mcp_sync   <= '0;
      mcp_prev   <= '0;
      fault_meta <= '0;
      fault_sync <= '0;
      sys_meta   <= 1'b0;
      sys_sync   <= 1'b0;
    end else begin
      det_meta   <= det_fire_in;
      det_sync   <= det_meta;
      det_prev   <= det_sync;
      mcp_meta   <= mcp_fire_in;
      mcp_sync   <= mcp_meta;
      mcp_prev   <= mcp_sync;
      fault_meta <= fault_in;
      fault_sync <= fault_meta;
      sys_meta   <= sys_fault_in;
      sys_sync   <= sys_meta;
    end
  end

  logic [NP-1:0]        det_rise;
  logic [NUM_ZONES-1:0] mcp_rise;
  assign det_rise = det_sync & ~det_prev;
  assign mcp_rise = mcp_sync & ~mcp_prev;

  // one-second enable
  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // register file
  fire_alarm_pkg::cfg_t  cfg;
  logic [2:0]            level;
  logic [10:0]           a_period;
  logic [15:0]           b_period;
  logic [9:0]            dly_init, dly_ext, dly_max;
  logic [19:0]           day_len;
  logic [NUM_FAULTS-1:0] fault_latch;

  logic apb_setup, apb_wr, rd_ok, wr_deny;
  logic [31:0] rd_data;
  logic [fire_alarm_pkg::CMD_WIDTH-1:0] cmd;
  logic lvl2, lvl3;

  assign apb_setup = psel_in & ~penable_in;
  assign apb_wr    = psel_in & penable_in & pready_out & pwrite_in;
  assign lvl2      = level >= fire_alarm_pkg::LVL_OPERATOR;
  assign lvl3      = level >= fire_alarm_pkg::LVL_CONFIG;
  assign cmd       = (apb_wr && paddr_in == fire_alarm_pkg::REG_CTRL && lvl2) ?
                     pwdata_in[fire_alarm_pkg::CMD_WIDTH-1:0] : '0;

  logic                  alarm, outputs_on, first_alarm, day_mode, new_zone;
  logic [NP-1:0]         hits, point_alarm;
  logic [NUM_ZONES-1:0]  mcp_hits, zone_alarm;
  logic [NUM_FAULTS-1:0] fault_stat;
  logic                  sys_fault;
  logic [NP-1:0]         armed;
  logic [31:0]           status;

  assign status = {23'h0, |armed, new_zone, sys_fault, |fault_stat, day_mode,
                   cfg.delays_perm | day_mode, first_alarm, outputs_on, alarm};

  always_comb begin
    rd_ok   = 1'b1;
    wr_deny = 1'b0;
    rd_data = '0;
    if (paddr_in == fire_alarm_pkg::REG_CTRL) begin
      wr_deny = ~lvl2;
    end else if (paddr_in == fire_alarm_pkg::REG_CFG) begin
      rd_data = 32'(cfg);
      // type b and c together is not a legal combination
      wr_deny = ~lvl3 | (pwdata_in[2] & pwdata_in[1]);
    end else if (paddr_in == fire_alarm_pkg::REG_ACCESS) begin
      rd_data = 32'(level);
    end else if (paddr_in == fire_alarm_pkg::REG_A_PERIOD) begin
      rd_data = 32'(a_period);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_B_PERIOD) begin
      rd_data = 32'(b_period);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_DLY_INIT) begin
      rd_data = 32'(dly_init);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_DLY_EXT) begin
      rd_data = 32'(dly_ext);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_DLY_MAX) begin
      rd_data = 32'(dly_max);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_DAY_LEN) begin
      rd_data = 32'(day_len);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_FAULT_LATCH) begin
      rd_data = 32'(fault_latch);
      wr_deny = ~lvl3;
    end else if (paddr_in == fire_alarm_pkg::REG_STATUS) begin
      rd_data = status;
      wr_deny = 1'b1;
    end else if (paddr_in == fire_alarm_pkg::REG_ZONE_ALARM) begin
      rd_data = 32'(zone_alarm);
      wr_deny = 1'b1;
    end else if (paddr_in == fire_alarm_pkg::REG_POINT_ALARM) begin
      rd_data = 32'(point_alarm);
      wr_deny = 1'b1;
    end else if (paddr_in == fire_alarm_pkg::REG_FAULT_STAT) begin
      rd_data = 32'(fault_stat);
      wr_deny = 1'b1;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // answer is prepared at the setup edge, so every transfer has exactly one access cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= apb_setup;
      prdata_out  <= (apb_setup & ~pwrite_in) ? rd_data : '0;
      pslverr_out <= apb_setup & (~rd_ok | (pwrite_in & wr_deny));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg         <= fire_alarm_pkg::CFG_RST;
      level       <= fire_alarm_pkg::LVL_RST;
      a_period    <= fire_alarm_pkg::A_PERIOD_RST;
      b_period    <= fire_alarm_pkg::B_PERIOD_RST;
      dly_init    <= fire_alarm_pkg::DLY_INIT_RST;
      dly_ext     <= fire_alarm_pkg::DLY_EXT_RST;
      dly_max     <= fire_alarm_pkg::DLY_MAX_RST;
      day_len     <= fire_alarm_pkg::DAY_LEN_RST;
      fault_latch <= '0;
    end else if (apb_wr && rd_ok && !wr_deny) begin
      if (paddr_in == fire_alarm_pkg::REG_CFG) begin
        cfg <= fire_alarm_pkg::cfg_t'(pwdata_in[6:0]);
      end else if (paddr_in == fire_alarm_pkg::REG_ACCESS) begin
        level <= 3'(clamp(20'(pwdata_in[2:0]), 20'(fire_alarm_pkg::LVL_RST), 20'(fire_alarm_pkg::LVL_TOP)));
      end else if (paddr_in == fire_alarm_pkg::REG_A_PERIOD) begin
        a_period <= 11'(clamp(20'(pwdata_in[15:0]), 20'(fire_alarm_pkg::A_REPEAT_S),
                              20'(fire_alarm_pkg::A_PERIOD_MAX_S)));
      end else if (paddr_in == fire_alarm_pkg::REG_B_PERIOD) begin
        b_period <= 16'(clamp(20'(pwdata_in[15:0]), 20'(fire_alarm_pkg::B_PERIOD_MIN_S), 20'hFFFF));
      end else if (paddr_in == fire_alarm_pkg::REG_DLY_INIT) begin
        dly_init <= pwdata_in[9:0];
      end else if (paddr_in == fire_alarm_pkg::REG_DLY_EXT) begin
        dly_ext <= pwdata_in[9:0];
      end else if (paddr_in == fire_alarm_pkg::REG_DLY_MAX) begin
        dly_max <= pwdata_in[9:0];
      end else if (paddr_in == fire_alarm_pkg::REG_DAY_LEN) begin
        day_len <= pwdata_in[19:0];
      end else if (paddr_in == fire_alarm_pkg::REG_FAULT_LATCH) begin
        fault_latch <= pwdata_in[NUM_FAULTS-1:0];
      end
    end
  end

  logic alarm_clr;
  assign alarm_clr = cmd[fire_alarm_pkg::CMD_ALARM_RST];

  // type a: first signal arms the point and resets its zone, the repeat confirms
  logic [NP-1:0]        ev_det;
  logic [NUM_ZONES-1:0] a_expire, first_arm;
  logic [10:0]          a_timer [NUM_ZONES];

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      ev_det[i] = cfg.dep_a ? (det_rise[i] & armed[i]) : det_rise[i];
    end
    first_arm = zones_of(det_rise & ~armed) & {NUM_ZONES{cfg.dep_a}};
    for (int z = 0; z < NUM_ZONES; z++) begin
      a_expire[z] = a_timer[z] >= a_period;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed          <= '0;
      zone_reset_out <= '0;
      local_warn_out <= 1'b0;
      for (int z = 0; z < NUM_ZONES; z++) begin
        a_timer[z] <= '0;
      end
    end else begin
      zone_reset_out <= first_arm;
      local_warn_out <= |armed;
      for (int i = 0; i < NP; i++) begin
        // a first signal in the clearing cycle still arms, its zone reset is already on its way
        if (!cfg.dep_a || ev_det[i]) begin
          armed[i] <= 1'b0;
        end else if (det_rise[i]) begin
          armed[i] <= 1'b1;
        end else if (alarm_clr || a_expire[i / PTS_PER_ZONE]) begin
          armed[i] <= 1'b0;
        end
      end
      for (int z = 0; z < NUM_ZONES; z++) begin
        if (!(|armed[z*PTS_PER_ZONE +: PTS_PER_ZONE]) || a_expire[z]) begin
          a_timer[z] <= '0;
        end else if (tick) begin
          a_timer[z] <= a_timer[z] + 11'h1;
        end
      end
    end
  end

  // alarm decision
  logic [15:0]          b_timer;
  logic                 b_cancel, alarm_next, new_zone_set;
  logic [NP-1:0]        hits_next, point_next;
  logic [NUM_ZONES-1:0] mcp_next, zone_next;

  always_comb begin
    b_cancel  = cfg.dep_b & ~alarm & (cmd[fire_alarm_pkg::CMD_CANCEL_B] |
                (cfg.b_auto & tick & (b_timer >= b_period)));
    hits_next = ((alarm_clr | b_cancel) ? '0 : hits) | ev_det;
    mcp_next  = (alarm_clr ? '0 : mcp_hits) | mcp_rise;
    alarm_next = (alarm & ~alarm_clr) | (|mcp_rise) | (~cfg.dep_b & (|ev_det)) |
                 (cfg.dep_b & (pop(32'(hits_next)) >= 6'h2));
    zone_next  = alarm_clr ? '0 : zone_alarm;
    point_next = alarm_clr ? '0 : point_alarm;
    if (alarm_next) begin
      zone_next  = zone_next | zones_of(hits_next) | mcp_next;
      point_next = point_next | hits_next;
    end
    new_zone_set = |(zone_next & ~zone_alarm);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm       <= 1'b0;
      hits        <= '0;
      mcp_hits    <= '0;
      zone_alarm  <= '0;
      point_alarm <= '0;
      new_zone    <= 1'b0;
      first_alarm <= 1'b0;
      b_timer     <= '0;
    end else begin
      alarm       <= alarm_next;
      hits        <= hits_next;
      mcp_hits    <= mcp_next;
      zone_alarm  <= zone_next;
      point_alarm <= point_next;
      // a zone arriving in the clearing cycle still raises the flag
      new_zone    <= new_zone_set | (new_zone & ~cmd[fire_alarm_pkg::CMD_NEWZ_CLR]);
      first_alarm <= cfg.dep_b & ~alarm_next & (|hits_next);
      if (!cfg.dep_b || alarm_next || !(|hits_next) || b_cancel) begin
        b_timer <= '0;
      end else if (tick && b_timer != 16'hFFFF) begin
        b_timer <= b_timer + 16'h1;
      end
    end
  end

  // output delays and day/night mode
  logic [19:0] day_cnt;
  logic [10:0] dly_limit, dly_cnt, ext_sum;
  logic        delays_on, expired, second_sig, gate, mcp_nodelay;

  assign delays_on   = cfg.delays_perm | day_mode;
  assign expired     = dly_cnt >= dly_limit;
  assign second_sig  = (pop(32'(hits)) + pop(32'(mcp_hits))) >= 6'h2;
  assign mcp_nodelay = (|mcp_hits) & ~cfg.mcp_delay;
  assign ext_sum     = dly_limit + 11'(dly_ext);
  assign gate        = cfg.dep_c ? (second_sig | (delays_on & expired)) :
                       (~delays_on | expired | mcp_nodelay);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      outputs_on <= 1'b0;
      dly_limit  <= '0;
      dly_cnt    <= '0;
    end else begin
      if (alarm_clr) begin
        outputs_on <= 1'b0;
      end else if (alarm && (gate || (cfg.mcp_override && (|mcp_hits)))) begin
        outputs_on <= 1'b1;
      end
      if (alarm_next && !alarm) begin
        dly_limit <= (dly_init > dly_max) ? 11'(dly_max) : 11'(dly_init);
        dly_cnt   <= '0;
      end else if (alarm && !outputs_on) begin
        if (cmd[fire_alarm_pkg::CMD_EXTEND]) begin
          dly_limit <= (ext_sum > 11'(dly_max)) ? 11'(dly_max) : ext_sum;
        end
        if (tick && !expired) begin
          dly_cnt <= dly_cnt + 11'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      day_mode <= 1'b0;
      day_cnt  <= '0;
    end else if (cmd[fire_alarm_pkg::CMD_DAY_ON]) begin
      day_mode <= 1'b1;
      day_cnt  <= day_len;
    end else if (cmd[fire_alarm_pkg::CMD_DAY_OFF]) begin
      day_mode <= 1'b0;
    end else if (day_mode && tick && day_cnt != '0) begin
      day_cnt <= day_cnt - 20'h1;
      if (day_cnt == 20'h1) begin
        day_mode <= 1'b0;
      end
    end
  end

  // faults are shown on fault_out four cycles after the pin, far inside the allowed time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_stat <= '0;
      sys_fault  <= 1'b0;
    end else begin
      fault_stat <= fault_sync | (fault_stat & fault_latch &
                    {NUM_FAULTS{~cmd[fire_alarm_pkg::CMD_FAULT_RST]}});
      sys_fault  <= sys_sync | (sys_fault & ~cmd[fire_alarm_pkg::CMD_FAULT_RST]);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_out          <= 1'b0;
      outputs_active_out <= 1'b0;
      first_alarm_out    <= 1'b0;
      zone_alarm_out     <= '0;
      new_zone_out       <= 1'b0;
      delays_on_out      <= 1'b0;
      fault_out          <= 1'b0;
      sys_fault_out      <= 1'b0;
    end else begin
      alarm_out          <= alarm;
      outputs_active_out <= outputs_on;
      first_alarm_out    <= first_alarm;
      zone_alarm_out     <= zone_alarm;
      new_zone_out       <= new_zone;
      delays_on_out      <= day_mode;
      fault_out          <= (|fault_stat) | sys_fault;
      sys_fault_out      <= sys_fault;
    end
  end

endmodule // fire_alarm_dependency_ctrl
`default_nettype wire

//--- dv/fire_alarm_dependency_ctrl_assertions.sv
// port checker for the fire alarm decision block
`timescale 1ns/1ps
`default_nettype none
module fire_alarm_dependency_ctrl_assertions #(
  parameter int unsigned NUM_ZONES  = 4,
  parameter int unsigned NUM_FAULTS = 8
) (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [7:0]            paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic                  pready_out,
  input wire logic [NUM_FAULTS-1:0] fault_in,
  input wire logic                  alarm_out,
  input wire logic                  outputs_active_out,
  input wire logic                  first_alarm_out,
  input wire logic                  local_warn_out,
  input wire logic [NUM_ZONES-1:0]  zone_reset_out,
  input wire logic [NUM_ZONES-1:0]  zone_alarm_out,
  input wire logic                  new_zone_out,
  input wire logic                  fault_out,
  input wire logic                  sys_fault_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic clr;
  // the clearing write reaches sys_fault_out two edges after it is seen, hence the past term below
  assign clr = psel_in && penable_in && pwrite_in && paddr_in == fire_alarm_pkg::REG_CTRL && pwdata_in[4];
  property p_ready;
    psel_in && !penable_in |=> pready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("access phase not answered");
  property p_rst;
    $past(rst_in) |-> !alarm_out && !outputs_active_out && zone_alarm_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("alarm state survived reset");
  property p_newz;
    (zone_alarm_out & ~$past(zone_alarm_out)) != '0 |-> new_zone_out;
  endproperty
  a_newz: assert property (p_newz) else $error("new zone not flagged");
  property p_zalm;
    $rose(alarm_out) |-> zone_alarm_out != '0;
  endproperty
  a_zalm: assert property (p_zalm) else $error("alarm without zone");
  property p_sysf;
    sys_fault_out && !clr && !$past(clr) |=> sys_fault_out;
  endproperty
  a_sysf: assert property (p_sysf) else $error("system fault dropped");
  property p_flt;
    fault_in != '0 [*6] |-> fault_out;
  endproperty
  a_flt: assert property (p_flt) else $error("fault not shown");
  property p_zrst;
    zone_reset_out != '0 |-> ##[0:1] local_warn_out;
  endproperty
  a_zrst: assert property (p_zrst) else $error("armed point without warning");
  property p_outs;
    outputs_active_out |-> alarm_out;
  endproperty
  a_outs: assert property (p_outs) else $error("outputs outside alarm");
  c_alarm: cover property (alarm_out && outputs_active_out);
  c_first: cover property (first_alarm_out);
  c_sysf: cover property ($fell(sys_fault_out));
endmodule // fire_alarm_dependency_ctrl_assertions
bind fire_alarm_dependency_ctrl fire_alarm_dependency_ctrl_assertions #(
  .NUM_ZONES(NUM_ZONES), .NUM_FAULTS(NUM_FAULTS)) chk_i (.*);
`default_nettype wire

//--- dv/fire_points_model.sv
// two-state detectors: latch on smoke, drop only on rst_in or when their zone is reset
`timescale 1ns/1ps
`default_nettype none
module fire_points_model (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] smoke_in,
  input wire logic [3:0]  zone_reset_in,
  output logic     [15:0] det_out
);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      det_out <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        det_out[i] <= smoke_in[i] | (det_out[i] & !zone_reset_in[i/4]);
      end
    end
  end
endmodule // fire_points_model
`default_nettype wire

//--- dv/fire_alarm_dependency_ctrl_tb.sv
// self-checking bench for the fire alarm decision block
`timescale 1ns/1ps
`default_nettype none
module fire_alarm_dependency_ctrl_tb;
  logic        clk_in, rst_in, prst, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, sys_fault_in;
  logic        alarm_out, outputs_active_out, first_alarm_out, local_warn_out, new_zone_out;
  logic        delays_on_out, fault_out, sys_fault_out;
  logic [7:0]  paddr_in, fault_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [15:0] smoke, det_fire_in;
  logic [3:0]  mcp_fire_in, zone_reset_out, zone_alarm_out;
  logic [31:0] rv [9] = '{32'h0, 32'h1, 32'h3C, 32'h12C, 32'h1E, 32'h3C, 32'h258, 32'hA8C0, 32'h0};
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  // short tick keeps the minute-scale timers within the run
  fire_alarm_dependency_ctrl #(.TICK_CYCLES(10)) dut (.*);
  fire_points_model pts (.clk_in(clk_in), .rst_in(prst), .smoke_in(smoke), .zone_reset_in(zone_reset_out),
                         .det_out(det_fire_in));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'(x));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic fire(input int i);
    smoke[i] <= 1'b1;
    @(posedge clk_in);
    smoke[i] <= 1'b0;
  endtask
  task automatic clean;
    mcp_fire_in <= 4'h0;
    wr(8'h00, 32'h61, 1'b0);
    prst <= 1'b1;
    t(1);
    prst <= 1'b0;
    t(6);
  endtask
  initial begin
    {rst_in, prst, psel_in, penable_in, pwrite_in, sys_fault_in} = 6'h30;
    {paddr_in, pwdata_in, smoke, mcp_fire_in, fault_in} = '0;
    t(8);
    {rst_in, prst} <= 2'h0;
    for (int i = 0; i < 9; i++) rd(8'(4 + 4 * i), rv[i]);
    wr(8'h40, 32'h0, 1'b1);
    wr(8'h04, 32'h1, 1'b1);
    wr(8'h00, 32'h4, 1'b1);
    wr(8'h08, 32'h3, 1'b0);
    wr(8'h04, 32'h6, 1'b1);
    wr(8'h28, 32'h0, 1'b1);
    wr(8'h0C, 32'h7D0, 1'b0);
    rd(8'h0C, 32'h708);
    wr(8'h10, 32'h64, 1'b0);
    rd(8'h10, 32'h12C);
    wr(8'h04, 32'h1, 1'b0);
    fire(4);
    t(10);
    chk(32'({alarm_out, local_warn_out, det_fire_in[4]}), 32'h2);
    fire(4);
    t(10);
    chk(32'({alarm_out, new_zone_out, zone_alarm_out}), 32'h32);
    rd(8'h30, 32'h10);
    clean();
    chk(32'({alarm_out, new_zone_out, zone_alarm_out}), 32'h0);
    wr(8'h04, 32'h2, 1'b0);
    fire(0);
    t(10);
    chk(32'({alarm_out, first_alarm_out}), 32'h1);
    wr(8'h00, 32'h1, 1'b0);
    t(2);
    chk(32'(first_alarm_out), 32'h0);
    fire(1);
    t(10);
    chk(32'({alarm_out, first_alarm_out}), 32'h1);
    fire(5);
    t(10);
    chk(32'({alarm_out, zone_alarm_out[1]}), 32'h3);
    clean();
    wr(8'h04, 32'hA, 1'b0);
    fire(2);
    t(2900);
    chk(32'(first_alarm_out), 32'h1);
    t(300);
    chk(32'(first_alarm_out), 32'h0);
    clean();
    wr(8'h04, 32'h4, 1'b0);
    mcp_fire_in <= 4'h4;
    t(10);
    chk(32'({alarm_out, outputs_active_out}), 32'h2);
    fire(8);
    t(10);
    chk(32'(outputs_active_out), 32'h1);
    clean();
    wr(8'h1C, 32'h28, 1'b0);
    wr(8'h00, 32'h4, 1'b0);
    t(4);
    chk(32'(delays_on_out), 32'h1);
    fire(12);
    // the delay window opens with the alarm, so extend only once it is up
    t(6);
    wr(8'h00, 32'h2, 1'b0);
    t(330);
    chk(32'({alarm_out, outputs_active_out}), 32'h2);
    t(110);
    chk(32'(outputs_active_out), 32'h1);
    clean();
    wr(8'h04, 32'h60, 1'b0);
    fire(12);
    t(10);
    chk(32'({alarm_out, outputs_active_out}), 32'h2);
    mcp_fire_in <= 4'h1;
    t(10);
    chk(32'(outputs_active_out), 32'h1);
    clean();
    wr(8'h00, 32'h8, 1'b0);
    t(4);
    chk(32'(delays_on_out), 32'h0);
    wr(8'h24, 32'h1, 1'b0);
    fault_in <= 8'h3;
    t(8);
    chk(32'(fault_out), 32'h1);
    fault_in <= 8'h0;
    t(8);
    rd(8'h34, 32'h1);
    sys_fault_in <= 1'b1;
    t(8);
    sys_fault_in <= 1'b0;
    t(8);
    chk(32'(sys_fault_out), 32'h1);
    wr(8'h00, 32'h10, 1'b0);
    t(4);
    chk(32'({fault_out, sys_fault_out}), 32'h0);
    mcp_fire_in <= 4'h2;
    t(10);
    rst_in <= 1'b1;
    t(2);
    chk(32'(alarm_out), 32'h0);
    rst_in <= 1'b0;
    rd(8'h08, 32'h1);
    conclude();
  end
endmodule // fire_alarm_dependency_ctrl_tb
`default_nettype wire
